/* logic/nmaq_pkg.sv */
// Operation
// - opcode f8h decodes as 28-bit native query
// - f8h reports the native max register as loaded by set-max
// - 48-bit max above 28 bits saturates
// - lba mode: sector number holds bits 7:0
// - cyl low bits 15:8, cyl high 23:16
// - head bits hold lba bits 27:24
// - chs mode returns sector, cylinder, head
// - opcode 27h reports full 48-bit native max
// - 27h sector number: 7:0, hob 31:24
// - 27h cyl low: 15:8, hob 39:32
// - 27h cyl high: 23:16, hob 47:40
package nmaq_pkg;
  localparam logic [7:0] OP_NATIVE28 = 8'hf8;
  localparam logic [7:0] OP_NATIVE48 = 8'h27;
  localparam logic [27:0] LBA28_SAT = 28'hfffffff;
  // register offsets on the plain port
  localparam logic [3:0] A_ERROR = 4'h1;
  localparam logic [3:0] A_SECNUM = 4'h3;
  localparam logic [3:0] A_CYLLO = 4'h4;
  localparam logic [3:0] A_CYLHI = 4'h5;
  localparam logic [3:0] A_DEVHEAD = 4'h6;
  localparam logic [3:0] A_CMD = 4'h7;
  localparam logic [3:0] A_DEVCTL = 4'he;
  localparam logic [3:0] A_IRQ_STAT = 4'h8;
  localparam logic [3:0] A_IRQ_MASK = 4'h9;
  localparam logic [3:0] A_NMAX0 = 4'ha;
  localparam logic [3:0] A_NMAX1 = 4'hb;
  // field positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DF = 5;
  localparam int ST_ERR = 0;
  localparam int ER_ABT = 2;
  localparam int DH_L = 6;
  localparam int DC_HOB = 7;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  // reset values
  localparam logic [7:0] STATUS_RST = 8'h40;
  localparam logic [7:0] DEVHEAD_RST = 8'ha0;
  localparam logic [47:0] NMAX_RST = 48'h0000_0fff_ffff;
  localparam logic [15:0] CHS_CYL_RST = 16'h3fff;
  localparam logic [3:0] CHS_HEAD_RST = 4'hf;
  localparam logic [7:0] CHS_SEC_RST = 8'h3f;
  // busy time: 1 us at 50 ns clock
  localparam int BUSY_NS = 1000;
  localparam int CLK_NS = 50;
  localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    NMAQ_IDLE = 2'b00,
    NMAQ_BUSY = 2'b01,
    NMAQ_DONE = 2'b11
  } nmaq_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } nmaq_bus_s;

  typedef struct packed {
    logic [7:0] secnum;
    logic [7:0] cyllo;
    logic [7:0] cylhi;
  } nmaq_trip_s;
endpackage : nmaq_pkg

/* logic/nmaq_result.sv */
`timescale 1ns/100ps
// builds both halves of the answer registers from the native max, except the low half and head of a 28-bit query in chs mode, which come from the chs inputs
module nmaq_result (
  input wire logic is_ext,
  input wire logic lba_mode,
  input wire logic [47:0] native_max,
  input wire logic [15:0] chs_cyl,
  input wire logic [3:0] chs_head,
  input wire logic [7:0] chs_sec,
  output nmaq_pkg::nmaq_trip_s low_half,
  output nmaq_pkg::nmaq_trip_s high_half,
  output logic [3:0] head
);
  logic [27:0] lba28;
  always_comb
  begin
    // saturate rather than wrap so old hosts never see a small disk
    if (native_max[47:28] != 20'h00000)
      lba28 = nmaq_pkg::LBA28_SAT;
    else
      lba28 = native_max[27:0];
    high_half = '{native_max[31:24], native_max[39:32], native_max[47:40]};
    head = 4'h0;
    if (is_ext)
    begin
      low_half = '{native_max[7:0], native_max[15:8], native_max[23:16]};
    end
    else if (lba_mode)
    begin
      low_half = '{lba28[7:0], lba28[15:8], lba28[23:16]};
      head = lba28[27:24];
    end
    else
    begin
      low_half = '{chs_sec, chs_cyl[7:0], chs_cyl[15:8]};
      head = chs_head;
    end
  end
endmodule : nmaq_result

/* logic/nmaq_top.sv */
`timescale 1ns/100ps
module nmaq_top #(
  parameter int BUSY_CYCLES = nmaq_pkg::BUSY_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] chs_cyl,
  input wire logic [3:0] chs_head,
  input wire logic [7:0] chs_sec,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic busy
);
  typedef struct packed {
    nmaq_pkg::nmaq_state_e st;
    logic [7:0] cnt;
    logic [7:0] status;
    logic [7:0] err;
    logic [7:0] devhead;
    logic hob;
    logic is_ext;
    nmaq_pkg::nmaq_trip_s lo;
    nmaq_pkg::nmaq_trip_s hi;
    logic [47:0] nmax;
    logic [1:0] istat;
    logic [1:0] imask;
    logic [7:0] rdata;
    logic irq;
  } nmaq_st_s;

  nmaq_st_s s_r, s_nxt;
  nmaq_pkg::nmaq_bus_s bus;
  nmaq_pkg::nmaq_trip_s res_lo, res_hi;
  logic [3:0] res_head;
  logic [1:0] ev;
  logic [7:0] cyc_lim;

  assign bus = '{reg_addr, reg_wdata, reg_wr, reg_rd};
  assign cyc_lim = 8'(BUSY_CYCLES);

  nmaq_result u_res (
    .is_ext(s_r.is_ext),
    .lba_mode(s_r.devhead[nmaq_pkg::DH_L]),
    .native_max(s_r.nmax),
    .chs_cyl(chs_cyl),
    .chs_head(chs_head),
    .chs_sec(chs_sec),
    .low_half(res_lo),
    .high_half(res_hi),
    .head(res_head)
  );

  always_comb
  begin
    s_nxt = s_r;
    ev = 2'b00;
    s_nxt.rdata = 8'h00;
    case (s_r.st)
      nmaq_pkg::NMAQ_IDLE:
      begin
        if (bus.wr && bus.addr == nmaq_pkg::A_CMD)
        begin
          s_nxt.status[nmaq_pkg::ST_BSY] = 1'b1;
          s_nxt.status[nmaq_pkg::ST_RDY] = 1'b0;
          s_nxt.err = 8'h00;
          s_nxt.cnt = 8'h00;
          if (bus.wdata == nmaq_pkg::OP_NATIVE28 || bus.wdata == nmaq_pkg::OP_NATIVE48)
          begin
            s_nxt.is_ext = (bus.wdata == nmaq_pkg::OP_NATIVE48);
            s_nxt.st = nmaq_pkg::NMAQ_BUSY;
          end
          else
          begin
            // unknown opcode: reject at once
            s_nxt.status = nmaq_pkg::STATUS_RST;
            s_nxt.status[nmaq_pkg::ST_ERR] = 1'b1;
            s_nxt.err[nmaq_pkg::ER_ABT] = 1'b1;
            ev[nmaq_pkg::IRQ_ABORT] = 1'b1;
          end
        end
      end
      nmaq_pkg::NMAQ_BUSY:
      begin
        s_nxt.cnt = s_r.cnt + 8'h01;
        if (s_r.cnt + 8'h01 >= cyc_lim)
          s_nxt.st = nmaq_pkg::NMAQ_DONE;
      end
      nmaq_pkg::NMAQ_DONE:
      begin
        s_nxt.lo = res_lo;
        s_nxt.hi = res_hi;
        if (!s_r.is_ext)
          s_nxt.devhead[3:0] = res_head;
        s_nxt.status = nmaq_pkg::STATUS_RST;
        s_nxt.err = 8'h00;
        ev[nmaq_pkg::IRQ_DONE] = 1'b1;
        s_nxt.st = nmaq_pkg::NMAQ_IDLE;
      end
      default:
        s_nxt.st = nmaq_pkg::NMAQ_IDLE;
    endcase
    // host side register writes; taskfile locked while busy
    if (bus.wr && s_r.st == nmaq_pkg::NMAQ_IDLE)
    begin
      case (bus.addr)
        nmaq_pkg::A_DEVHEAD: s_nxt.devhead = bus.wdata;
        nmaq_pkg::A_DEVCTL: s_nxt.hob = bus.wdata[nmaq_pkg::DC_HOB];
        nmaq_pkg::A_IRQ_MASK: s_nxt.imask = bus.wdata[1:0];
        nmaq_pkg::A_NMAX0: s_nxt.nmax = {s_r.nmax[47:8], bus.wdata};
        nmaq_pkg::A_NMAX1: s_nxt.nmax = {bus.wdata, s_r.nmax[47:8]};
        default: s_nxt.nmax = s_r.nmax;
      endcase
    end
    if (bus.rd)
    begin
      case (bus.addr)
        nmaq_pkg::A_ERROR: s_nxt.rdata = s_r.err;
        nmaq_pkg::A_SECNUM: s_nxt.rdata = s_r.hob ? s_r.hi.secnum : s_r.lo.secnum;
        nmaq_pkg::A_CYLLO: s_nxt.rdata = s_r.hob ? s_r.hi.cyllo : s_r.lo.cyllo;
        nmaq_pkg::A_CYLHI: s_nxt.rdata = s_r.hob ? s_r.hi.cylhi : s_r.lo.cylhi;
        nmaq_pkg::A_DEVHEAD: s_nxt.rdata = s_r.devhead;
        nmaq_pkg::A_CMD: s_nxt.rdata = s_r.status;
        nmaq_pkg::A_IRQ_STAT: s_nxt.rdata = {6'h00, s_r.istat};
        nmaq_pkg::A_IRQ_MASK: s_nxt.rdata = {6'h00, s_r.imask};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    // read clears status, but a new event in the same cycle wins
    if (bus.rd && bus.addr == nmaq_pkg::A_IRQ_STAT)
      s_nxt.istat = ev;
    else
      s_nxt.istat = s_r.istat | ev;
    s_nxt.irq = |(s_nxt.istat & s_nxt.imask);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_r <= '0;
      s_r.st <= nmaq_pkg::NMAQ_IDLE;
      s_r.status <= nmaq_pkg::STATUS_RST;
      s_r.devhead <= nmaq_pkg::DEVHEAD_RST;
      s_r.nmax <= nmaq_pkg::NMAX_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign reg_rdata = s_r.rdata;
  assign irq = s_r.irq;
  assign busy = s_r.status[nmaq_pkg::ST_BSY];

  a_done_status: assert property (@(posedge clock) disable iff (sys_rst)
    s_r.st == nmaq_pkg::NMAQ_DONE |=> s_r.status == nmaq_pkg::STATUS_RST && s_r.err == 8'h00)
    else $error("status not clean after completion");
  a_busy_start: assert property (@(posedge clock) disable iff (sys_rst)
    s_r.st == nmaq_pkg::NMAQ_IDLE && bus.wr && bus.addr == nmaq_pkg::A_CMD
    && bus.wdata == nmaq_pkg::OP_NATIVE28 |=> busy && s_r.st == nmaq_pkg::NMAQ_BUSY)
    else $error("query not accepted");
  a_reject_abort: assert property (@(posedge clock) disable iff (sys_rst)
    s_r.st == nmaq_pkg::NMAQ_IDLE && bus.wr && bus.addr == nmaq_pkg::A_CMD
    && bus.wdata != nmaq_pkg::OP_NATIVE28 && bus.wdata != nmaq_pkg::OP_NATIVE48
    |=> s_r.err == 8'h04 && s_r.status == 8'h41)
    else $error("reject did not abort");
  a_sat_value: assert property (@(posedge clock) disable iff (sys_rst)
    s_r.st == nmaq_pkg::NMAQ_DONE && !s_r.is_ext && s_r.devhead[nmaq_pkg::DH_L]
    && s_r.nmax[47:28] != 20'h00000
    |=> {s_r.devhead[3:0], s_r.lo.cylhi, s_r.lo.cyllo, s_r.lo.secnum} == nmaq_pkg::LBA28_SAT)
    else $error("no saturation");
  a_ext_low: assert property (@(posedge clock) disable iff (sys_rst)
    s_r.st == nmaq_pkg::NMAQ_DONE && s_r.is_ext
    |=> {s_r.hi.cylhi, s_r.hi.cyllo, s_r.hi.secnum, s_r.lo.cylhi, s_r.lo.cyllo, s_r.lo.secnum}
    == $past(s_r.nmax))
    else $error("ext halves wrong");
  a_hob_read: assert property (@(posedge clock) disable iff (sys_rst)
    bus.rd && bus.addr == nmaq_pkg::A_CYLLO && s_r.hob |=> reg_rdata == $past(s_r.hi.cyllo))
    else $error("hob read wrong");
  a_chs_sec: assert property (@(posedge clock) disable iff (sys_rst)
    s_r.st == nmaq_pkg::NMAQ_DONE && !s_r.is_ext && !s_r.devhead[6]
    |=> s_r.lo.secnum == $past(chs_sec) && s_r.devhead[3:0] == $past(chs_head))
    else $error("chs answer wrong");
  // busy spans the programmed wait plus the answer cycle; needs BUSY_CYCLES of one or more
  a_busy_len: assert property (@(posedge clock) disable iff (sys_rst)
    s_r.st == nmaq_pkg::NMAQ_DONE |-> busy && s_r.cnt == cyc_lim)
    else $error("busy length wrong");
endmodule : nmaq_top

/* tb/nmaq_host.sv */
`timescale 1ns/100ps
// host side of the task file: one strobe per access, then a quiet cycle
module nmaq_host (
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  input wire logic busy,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    // released data must not keep its last value
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // results are only read once busy has dropped
  // busy updates in the edge that takes the command, so look just after it;
  // a hang is caught by the bench's cycle ceiling
  task automatic cmd(input logic [7:0] op);
    wr(nmaq_pkg::A_CMD, op);
    #1;
    while (busy !== 1'b0)
    begin
      @(posedge clock);
      #1;
    end
  endtask : cmd
endmodule : nmaq_host

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic clock;
  logic sys_rst;
  logic [15:0] chs_cyl;
  logic [3:0] chs_head;
  logic [7:0] chs_sec;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic irq;
  logic busy;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  nmaq_top #(.BUSY_CYCLES(2)) i_dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .chs_cyl(chs_cyl),
    .chs_head(chs_head), .chs_sec(chs_sec), .reg_rdata(reg_rdata), .irq(irq), .busy(busy));
  nmaq_host i_host (.clock(clock), .reg_rdata(reg_rdata), .busy(busy), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // whole run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_host.rd(a, v);
    if (a == nmaq_pkg::A_DEVHEAD)
      v = {4'h0, v[3:0]};
    chk(what, e, v);
  endtask : rchk
  // shift-in register takes the low byte first
  task automatic set_max(input logic [47:0] m);
    for (int i = 0; i < 6; i++)
      i_host.wr(nmaq_pkg::A_NMAX1, m[8*i +: 8]);
  endtask : set_max
  task automatic answer(input logic [23:0] t, input logic [7:0] h);
    rchk("secnum", nmaq_pkg::A_SECNUM, t[7:0]);
    rchk("cyllo", nmaq_pkg::A_CYLLO, t[15:8]);
    rchk("cylhi", nmaq_pkg::A_CYLHI, t[23:16]);
    if (h !== 8'hff)
      rchk("head", nmaq_pkg::A_DEVHEAD, h);
  endtask : answer
  task automatic t_lba28();
    set_max(48'h0000_0abc_de12);
    i_host.wr(nmaq_pkg::A_DEVHEAD, 8'he0);
    i_host.cmd(nmaq_pkg::OP_NATIVE28);
    answer(24'hbcde12, 8'h0a);
    rchk("status", nmaq_pkg::A_CMD, 8'h40);
    rchk("error", nmaq_pkg::A_ERROR, 8'h00);
    set_max(48'h0001_2345_6789);
    i_host.cmd(nmaq_pkg::OP_NATIVE28);
    answer(24'hffffff, 8'h0f);
  endtask : t_lba28
  task automatic t_chs();
    @(posedge clock);
    chs_cyl <= 16'h1234;
    chs_head <= 4'h5;
    chs_sec <= 8'h2a;
    i_host.wr(nmaq_pkg::A_DEVHEAD, 8'ha0);
    i_host.cmd(nmaq_pkg::OP_NATIVE28);
    answer(24'h12342a, 8'h05);
  endtask : t_chs
  task automatic t_ext();
    set_max(48'hfedc_ba98_7654);
    i_host.wr(nmaq_pkg::A_DEVCTL, 8'h00);
    i_host.cmd(nmaq_pkg::OP_NATIVE48);
    answer(24'h987654, 8'hff);
    i_host.wr(nmaq_pkg::A_DEVCTL, 8'h80);
    answer(24'hfedcba, 8'hff);
    i_host.wr(nmaq_pkg::A_DEVCTL, 8'h00);
  endtask : t_ext
  task automatic t_abort_irq();
    logic [7:0] v;
    i_host.rd(nmaq_pkg::A_IRQ_STAT, v);
    i_host.wr(nmaq_pkg::A_IRQ_MASK, 8'h03);
    i_host.cmd(8'h00);
    rchk("status", nmaq_pkg::A_CMD, 8'h41);
    rchk("error", nmaq_pkg::A_ERROR, 8'h04);
    chk("irq", 8'h01, {7'h0, irq});
    rchk("istat", nmaq_pkg::A_IRQ_STAT, 8'h02);
    @(posedge clock);
    #1;
    chk("irq", 8'h00, {7'h0, irq});
    i_host.wr(nmaq_pkg::A_IRQ_MASK, 8'h00);
    i_host.cmd(nmaq_pkg::OP_NATIVE48);
    chk("irq", 8'h00, {7'h0, irq});
    rchk("status", nmaq_pkg::A_CMD, 8'h40);
    rchk("istat", nmaq_pkg::A_IRQ_STAT, 8'h01);
    i_host.wr(nmaq_pkg::A_IRQ_MASK, 8'h01);
    i_host.cmd(nmaq_pkg::OP_NATIVE28);
    chk("irq", 8'h01, {7'h0, irq});
    rchk("istat", nmaq_pkg::A_IRQ_STAT, 8'h01);
    chk("irq", 8'h00, {7'h0, irq});
  endtask : t_abort_irq
  initial
  begin
    sys_rst = 1'b1;
    chs_cyl = 16'h0000;
    chs_head = 4'h0;
    chs_sec = 8'h00;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    rchk("status", nmaq_pkg::A_CMD, nmaq_pkg::STATUS_RST);
    t_lba28();
    t_chs();
    t_ext();
    t_abort_irq();
    tally_and_finish();
  end
endmodule : tb_top
